// >>> src/sldc_cfg.svh
// Purpose: Offsets, field positions and codes for the line context store
// Assumes: Included by the design file and the bench
// Notes:   Type codes equal the selector register type field values
`ifndef SLDC_CFG_SVH
`define SLDC_CFG_SVH

// Register type codes (selector bits 08-11)
`define SLDC_TX_PRI_ADDR   4'h0
`define SLDC_TX_PRI_COUNT  4'h1
`define SLDC_TX_ALT_ADDR   4'h2
`define SLDC_TX_ALT_COUNT  4'h3
`define SLDC_RX_ADDR       4'h4
`define SLDC_RX_COUNT      4'h5
`define SLDC_TX_CHECK      4'h6
`define SLDC_RX_CHECK      4'h7
`define SLDC_TX_TABLE      4'h8
`define SLDC_RX_TABLE      4'h9
`define SLDC_PROTOCOL      4'ha
`define SLDC_LINE_STATE    4'hb
`define SLDC_TX_MODE       4'hc
`define SLDC_RX_MODE       4'hd
`define SLDC_PROGRESS      4'he

// Selector fields
`define SLDC_SEL_LINE_LO   0
`define SLDC_SEL_TYPE_LO   8

// Byte count fields
`define SLDC_COUNT_MARK    15

// Line state fields
`define SLDC_LS_RX_ACTIVE  0
`define SLDC_LS_RESYNC     1
`define SLDC_LS_TX_GO      2
`define SLDC_LS_UNDERRUN   3
`define SLDC_LS_ALT        7
`define SLDC_LS_EXPECT     10
`define SLDC_LS_NEXT_LO    13

// Line progress fields
`define SLDC_LP_SEND1      0
`define SLDC_LP_SEND2      1
`define SLDC_LP_ESCAPE     2
`define SLDC_LP_EXPECT1    5
`define SLDC_LP_EXPECT2    6
`define SLDC_LP_RESYNC     7
`define SLDC_LP_SEND_CHECK 10
`define SLDC_LP_NEXT_LO    13

// Protocol parameter fields
`define SLDC_PP_CHECK_LO   3

// Control byte field
`define SLDC_CB_INCLUDE    3

// Check type codes and polynomials (reflected)
`define SLDC_CHK_CRC16     2'h0
`define SLDC_CHK_CCITT     2'h1
`define SLDC_CHK_LRC8      2'h2
`define SLDC_POLY_CRC16    16'ha001
`define SLDC_POLY_CCITT    16'h8408

// Receive interrupt code for count reaching zero
`define SLDC_RX_ZERO_CODE  8'h05

`endif

// >>> src/sldc_pkg.sv
// Purpose: Types shared by the line context store
// Assumes: Uses no constants from sldc_cfg.svh
// Notes:   Requests and answers travel as packed structs
package sldc_pkg;

  // Engine operations
  typedef enum logic [2:0] {
    SLDC_OP_NONE,
    SLDC_OP_TX_CHAR,
    SLDC_OP_RX_CHAR,
    SLDC_OP_TX_CHECK,
    SLDC_OP_STATUS
  } sldc_op_type;

  // Engine request
  typedef struct packed {
    sldc_op_type op;
    logic [3:0]  line;
    logic [7:0]  data;
    logic [7:0]  ctrl;
  } sldc_req_type;

  // Engine answer
  typedef struct packed {
    logic        valid;
    logic [3:0]  line;
    logic [17:0] mem_addr;
    logic [17:0] ctrl_addr;
    logic        store_en;
    logic        count_zero;
    logic [2:0]  mode;
    logic        check_valid;
    logic [7:0]  check_byte;
    logic        rx_int;
    logic [7:0]  rx_int_code;
  } sldc_rsp_type;

endpackage : sldc_pkg

// >>> src/sldc_context.sv
// Purpose: Per-line context registers steering character transfers
// Assumes: One engine request and one host access per core_clk cycle
// Notes:   Host reaches the store through selector and access ports
//
// Operation
// - Marked transmit zero loads next transmit mode
// - Marked transmit zero sends check if enabled
// - Unmarked count keeps transmitter mode field
// - Primary count increments per sent character
// - Primary zero with go switches to alternate
// - Alternate zero with go returns to primary
// - Alternate address increments when alternate used
// - Counts are 15-bit, bit 15 marks
// - Addresses take extension bits on load
// - Receive address increments per stored character
// - Marked receive zero loads mode, expects check
// - Receive zero posts code, stops storing
// - Check sent low byte first, then cleared
// - Transmit check cleared after sending
// - Control byte bit 03 gates check update
// - CRCs bytewise, longitudinal check 8-bit
// - Control byte address from table base
// - Protocol parameters written by host
// - Line state fields and access rules
// - Mode field selects control table
// - Line progress is engine private state
// - Selector gives line and type
// - Control byte bit 03 includes character
`timescale 1ns/1ps
`default_nettype none
`include "sldc_cfg.svh"

module sldc_context
  import sldc_pkg::*;
#(
  parameter int LINES = 16,
  parameter int TYPES = 16
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Host selector and access
  input  wire logic         sel_wr,
  input  wire logic [15:0]  sel_wdata,
  input  wire logic         acc_wr,
  input  wire logic         acc_rd,
  input  wire logic [15:0]  acc_wdata,
  input  wire logic [1:0]   sys_ctl_ext,
  output logic [15:0]       sel_rdata,
  output logic [15:0]       acc_rdata,
  output logic [1:0]        ext_rdata,
  output logic              resync_req,
  // Engine request and answer
  input  wire sldc_req_type req,
  output sldc_rsp_type      rsp
);

  localparam int IW = $clog2(LINES * TYPES);

  // Context store and address extensions
  logic [15:0] ctx [LINES * TYPES];
  logic [1:0]  ext [LINES * TYPES];
  logic [3:0]  sel_line;
  logic [3:0]  sel_type;

  // Flat index from line and type
  function automatic logic [IW-1:0] idx(input logic [3:0] line, input logic [3:0] typ);
    idx = IW'({line, typ});
  endfunction : idx

  // True for types holding 18-bit addresses
  function automatic logic is_addr(input logic [3:0] typ);
    is_addr = 1'b0;
    if (typ == `SLDC_TX_PRI_ADDR) begin
      is_addr = 1'b1;
    end else if (typ == `SLDC_TX_ALT_ADDR) begin
      is_addr = 1'b1;
    end else if (typ == `SLDC_RX_ADDR) begin
      is_addr = 1'b1;
    end else if (typ == `SLDC_TX_TABLE) begin
      is_addr = 1'b1;
    end else if (typ == `SLDC_RX_TABLE) begin
      is_addr = 1'b1;
    end
  endfunction : is_addr

  // One byte through the selected check
  function automatic logic [15:0] check_step(input logic [15:0] acc, input logic [7:0] data,
                                             input logic [1:0] kind);
    logic [15:0] c;
    logic [15:0] poly;
    c    = acc ^ {8'h00, data};
    poly = (kind == `SLDC_CHK_CCITT) ? `SLDC_POLY_CCITT : `SLDC_POLY_CRC16;
    // Longitudinal check is a plain xor
    if (kind == `SLDC_CHK_LRC8) begin
      check_step = {8'h00, acc[7:0] ^ data};
    end else begin
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ poly) : (c >> 1);
      end
      check_step = c;
    end
  endfunction : check_step

  // Engine view of the addressed line
  logic [3:0]  ln;
  logic        alt;
  logic [3:0]  ta;
  logic [3:0]  tc;
  logic [15:0] ls;
  logic [15:0] lp;
  logic [15:0] pp;
  logic [15:0] tx_cnt;
  logic [15:0] rx_cnt;
  logic [15:0] next_tx_cnt;
  logic [15:0] next_rx_cnt;
  logic [17:0] tx_addr;
  logic [17:0] rx_addr;
  logic [17:0] next_tx_addr;
  logic [17:0] next_rx_addr;
  logic        tx_zero;
  logic        rx_zero;
  logic        rx_stopped;
  logic        host_ls_hit;
  logic [15:0] host_ls_val;

  // Combinational views of the context
  always_comb begin
    ln           = req.line;
    ls           = ctx[idx(ln, `SLDC_LINE_STATE)];
    lp           = ctx[idx(ln, `SLDC_PROGRESS)];
    pp           = ctx[idx(ln, `SLDC_PROTOCOL)];

    // Active transmit table
    alt          = ls[`SLDC_LS_ALT];
    ta           = alt ? `SLDC_TX_ALT_ADDR : `SLDC_TX_PRI_ADDR;
    tc           = alt ? `SLDC_TX_ALT_COUNT : `SLDC_TX_PRI_COUNT;

    // Counts and current addresses
    tx_cnt       = ctx[idx(ln, tc)];
    rx_cnt       = ctx[idx(ln, `SLDC_RX_COUNT)];
    tx_addr      = {ext[idx(ln, ta)], ctx[idx(ln, ta)]};
    rx_addr      = {ext[idx(ln, `SLDC_RX_ADDR)], ctx[idx(ln, `SLDC_RX_ADDR)]};

    // Stepped counts and addresses
    next_tx_cnt  = {tx_cnt[`SLDC_COUNT_MARK], tx_cnt[14:0] + 15'h0001};
    next_rx_cnt  = {rx_cnt[`SLDC_COUNT_MARK], rx_cnt[14:0] + 15'h0001};
    next_tx_addr = tx_addr + 18'h00001;
    next_rx_addr = rx_addr + 18'h00001;

    // Zero detection
    tx_zero      = (next_tx_cnt[14:0] == 15'h0000);
    rx_zero      = (next_rx_cnt[14:0] == 15'h0000);
    rx_stopped   = (rx_cnt[14:0] == 15'h0000);

    // Host line state write seen by the engine
    host_ls_hit  = acc_wr && (sel_line == ln) && (sel_type == `SLDC_LINE_STATE);
    // Receiver active is device owned, underrun only clears from host
    host_ls_val  = acc_wdata;
    host_ls_val[`SLDC_LS_RX_ACTIVE] = ls[`SLDC_LS_RX_ACTIVE];
    host_ls_val[`SLDC_LS_RESYNC]    = 1'b0;
    host_ls_val[`SLDC_LS_UNDERRUN]  = ls[`SLDC_LS_UNDERRUN] & acc_wdata[`SLDC_LS_UNDERRUN];
  end

  // Selector register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sel_line <= 4'h0;
      sel_type <= 4'h0;
    end else if (sel_wr) begin
      sel_line <= sel_wdata[`SLDC_SEL_LINE_LO +: 4];
      sel_type <= sel_wdata[`SLDC_SEL_TYPE_LO +: 4];
    end
  end

  // Selector readback
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sel_rdata <= 16'h0000;
    end else if (sel_wr) begin
      sel_rdata <= {4'h0, sel_wdata[`SLDC_SEL_TYPE_LO +: 4], 4'h0, sel_wdata[`SLDC_SEL_LINE_LO +: 4]};
    end
  end

  // Host read port
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_rdata <= 16'h0000;
      ext_rdata <= 2'h0;
    end else if (acc_rd) begin
      acc_rdata <= ctx[idx(sel_line, sel_type)];
      ext_rdata <= ext[idx(sel_line, sel_type)];
    end
  end

  // Resynchronize request pulse from line state write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resync_req <= 1'b0;
    end else begin
      resync_req <= acc_wr && (sel_type == `SLDC_LINE_STATE) && acc_wdata[`SLDC_LS_RESYNC];
    end
  end

  // Context store: host writes first, engine updates after
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < LINES * TYPES; i++) begin
        ctx[i] <= 16'h0000;
        ext[i] <= 2'h0;
      end
    end else begin
      // Host write through the selector
      if (acc_wr) begin
        if (sel_type == `SLDC_LINE_STATE) begin
          ctx[idx(sel_line, sel_type)] <= host_ls_val;
        end else begin
          ctx[idx(sel_line, sel_type)] <= acc_wdata;
        end
        if (is_addr(sel_type)) begin
          ext[idx(sel_line, sel_type)] <= sys_ctl_ext;
        end
      end

      // Engine update of the addressed line
      case (req.op)
        SLDC_OP_TX_CHAR: begin
          ctx[idx(ln, tc)] <= next_tx_cnt;
          {ext[idx(ln, ta)], ctx[idx(ln, ta)]} <= next_tx_addr;
          if (req.ctrl[`SLDC_CB_INCLUDE]) begin
            ctx[idx(ln, `SLDC_TX_CHECK)] <= check_step(ctx[idx(ln, `SLDC_TX_CHECK)], req.data,
                                                      pp[`SLDC_PP_CHECK_LO +: 2]);
          end
          if (tx_zero) begin
            if (!tx_cnt[`SLDC_COUNT_MARK]) begin
              ctx[idx(ln, `SLDC_TX_MODE)] <= {13'h0000, lp[`SLDC_LP_NEXT_LO +: 3]};
              if (lp[`SLDC_LP_SEND_CHECK]) begin
                ctx[idx(ln, `SLDC_PROGRESS)] <= lp | (16'h0001 << `SLDC_LP_SEND1);
              end
            end
            if (ls[`SLDC_LS_TX_GO]) begin
              ctx[idx(ln, `SLDC_LINE_STATE)] <= (host_ls_hit ? host_ls_val : ls) ^
                                                (16'h0001 << `SLDC_LS_ALT);
            end
          end
        end
        // Received character unless the count is spent
        SLDC_OP_RX_CHAR: begin
          if (!rx_stopped) begin
            ctx[idx(ln, `SLDC_RX_COUNT)] <= next_rx_cnt;
            {ext[idx(ln, `SLDC_RX_ADDR)], ctx[idx(ln, `SLDC_RX_ADDR)]} <= next_rx_addr;
            if (req.ctrl[`SLDC_CB_INCLUDE]) begin
              ctx[idx(ln, `SLDC_RX_CHECK)] <= check_step(ctx[idx(ln, `SLDC_RX_CHECK)], req.data,
                                                        pp[`SLDC_PP_CHECK_LO +: 2]);
            end
            if (rx_zero && !rx_cnt[`SLDC_COUNT_MARK]) begin
              ctx[idx(ln, `SLDC_RX_MODE)] <= {13'h0000, ls[`SLDC_LS_NEXT_LO +: 3]};
              if (ls[`SLDC_LS_EXPECT]) begin
                ctx[idx(ln, `SLDC_PROGRESS)] <= lp | (16'h0001 << `SLDC_LP_EXPECT1);
              end
            end
          end
        end
        // Block check bytes, low byte first
        SLDC_OP_TX_CHECK: begin
          if (lp[`SLDC_LP_SEND1]) begin
            if (pp[`SLDC_PP_CHECK_LO +: 2] == `SLDC_CHK_LRC8) begin
              ctx[idx(ln, `SLDC_TX_CHECK)] <= 16'h0000;
              ctx[idx(ln, `SLDC_PROGRESS)] <= lp & ~(16'h0001 << `SLDC_LP_SEND1);
            end else begin
              ctx[idx(ln, `SLDC_PROGRESS)] <= (lp & ~(16'h0001 << `SLDC_LP_SEND1)) |
                                              (16'h0001 << `SLDC_LP_SEND2);
            end
          end else if (lp[`SLDC_LP_SEND2]) begin
            ctx[idx(ln, `SLDC_TX_CHECK)] <= 16'h0000;
            ctx[idx(ln, `SLDC_PROGRESS)] <= lp & ~(16'h0001 << `SLDC_LP_SEND2);
          end
        end
        SLDC_OP_STATUS: begin
          // Event bits set in line state; a same-cycle host clear loses
          ctx[idx(ln, `SLDC_LINE_STATE)] <= (host_ls_hit ? host_ls_val : ls) |
                                            {8'h00, req.data};
        end
        default: begin
        end
      endcase
    end
  end

  // Engine answer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp             <= '0;
      rsp.valid       <= (req.op != SLDC_OP_NONE);
      // Line echoed only with a request so idle answers stay zero
      if (req.op != SLDC_OP_NONE) begin
        rsp.line      <= ln;
      end
      case (req.op)
        SLDC_OP_TX_CHAR: begin
          rsp.mem_addr   <= tx_addr;
          rsp.ctrl_addr  <= {ext[idx(ln, `SLDC_TX_TABLE)], ctx[idx(ln, `SLDC_TX_TABLE)]} +
                            {10'h000, req.data};
          rsp.store_en   <= 1'b1;
          rsp.count_zero <= tx_zero;
          if (tx_zero && !tx_cnt[`SLDC_COUNT_MARK]) begin
            rsp.mode <= lp[`SLDC_LP_NEXT_LO +: 3];
          end else begin
            rsp.mode <= ctx[idx(ln, `SLDC_TX_MODE)][2:0];
          end
        end
        SLDC_OP_RX_CHAR: begin
          // Receive address and table from the receive side
          rsp.mem_addr   <= rx_addr;
          rsp.ctrl_addr  <= {ext[idx(ln, `SLDC_RX_TABLE)], ctx[idx(ln, `SLDC_RX_TABLE)]} +
                            {10'h000, req.data};
          rsp.store_en   <= !rx_stopped;
          rsp.count_zero <= !rx_stopped && rx_zero;
          rsp.rx_int     <= !rx_stopped && rx_zero;
          rsp.rx_int_code <= (!rx_stopped && rx_zero) ? `SLDC_RX_ZERO_CODE : 8'h00;
          if (!rx_stopped && rx_zero && !rx_cnt[`SLDC_COUNT_MARK]) begin
            rsp.mode <= ls[`SLDC_LS_NEXT_LO +: 3];
          end else begin
            rsp.mode <= ctx[idx(ln, `SLDC_RX_MODE)][2:0];
          end
        end
        SLDC_OP_TX_CHECK: begin
          rsp.check_valid <= lp[`SLDC_LP_SEND1] | lp[`SLDC_LP_SEND2];
          rsp.check_byte  <= lp[`SLDC_LP_SEND1] ? ctx[idx(ln, `SLDC_TX_CHECK)][7:0]
                                                : ctx[idx(ln, `SLDC_TX_CHECK)][15:8];
        end
        default: begin
        end
      endcase
    end
  end

endmodule : sldc_context
`default_nettype wire

// >>> sim/sldc_context_assertions.sv
// Purpose: Port timing relations of the line context store
// Assumes: Bound to sldc_context, one clock domain
// Notes:   Engine answers come exactly one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module sldc_context_assertions
  import sldc_pkg::*;
(
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         nrst,
  // Host side
  input wire logic         sel_wr,
  input wire logic [15:0]  sel_wdata,
  input wire logic         acc_wr,
  input wire logic         acc_rd,
  input wire logic [15:0]  acc_wdata,
  input wire logic [15:0]  sel_rdata,
  input wire logic [15:0]  acc_rdata,
  input wire logic         resync_req,
  // Engine side
  input wire sldc_req_type req,
  input wire sldc_rsp_type rsp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_rsp_valid; req.op != SLDC_OP_NONE |=> rsp.valid && rsp.line == $past(req.line); endproperty
  a_rsp_valid: assert property (p_rsp_valid) else $error("answer missing");
  property p_rsp_idle; req.op == SLDC_OP_NONE |=> rsp == '0; endproperty
  a_rsp_idle: assert property (p_rsp_idle) else $error("answer without request");
  property p_rx_code; rsp.rx_int |-> rsp.count_zero && rsp.rx_int_code == 8'h05; endproperty
  a_rx_code: assert property (p_rx_code) else $error("bad receive code");
  property p_check_src; rsp.check_valid |-> $past(req.op) == SLDC_OP_TX_CHECK; endproperty
  a_check_src: assert property (p_check_src) else $error("stray check byte");
  property p_addr_inc;
    (req.op == SLDC_OP_TX_CHAR) ##1 (req.op == SLDC_OP_TX_CHAR && req.line == $past(req.line) && !rsp.count_zero)
    |=> rsp.mem_addr == $past(rsp.mem_addr) + 18'h1;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address not stepped");
  property p_resync_cause;
    $rose(resync_req) |-> $past(acc_wr) && $past(acc_wdata[1]) && $past(sel_rdata[11:8]) == 4'hb;
  endproperty
  a_resync_cause: assert property (p_resync_cause) else $error("resync without write");
  property p_resync_pulse; resync_req |=> !resync_req; endproperty
  a_resync_pulse: assert property (p_resync_pulse) else $error("resync too long");
  property p_sel_echo; sel_wr |=> sel_rdata == {4'h0, $past(sel_wdata[11:8]), 4'h0, $past(sel_wdata[3:0])}; endproperty
  a_sel_echo: assert property (p_sel_echo) else $error("selector mismatch");
  property p_rd_hold; !acc_rd |=> $stable(acc_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : sldc_context_assertions
`default_nettype wire

// >>> sim/sldc_engine_model.sv
// Purpose: Character engine that issues requests to the context store
// Assumes: Tasks are called at a falling edge of core_clk
// Notes:   Requests back to back when calls follow each other
`timescale 1ns/1ps
`default_nettype none
module sldc_engine_model
  import sldc_pkg::*;
(
  // Clock
  input wire logic         core_clk,
  // Request and answer
  output var sldc_req_type req,
  input wire sldc_rsp_type rsp
);
  // Idle from time zero
  initial req = '0;
  // Present one character and take its answer one cycle on
  task automatic send(input sldc_op_type op, input logic [3:0] ln, input logic [7:0] dt, cb,
                      output sldc_rsp_type got);
    req = '{op, ln, dt, cb};
    @(negedge core_clk);
    got = rsp;
  endtask : send
  task automatic idle();
    req.op = SLDC_OP_NONE;
  endtask : idle
endmodule : sldc_engine_model
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench of the line context store
// Assumes: Inputs change at falling edges
// Notes:   Register table first, then transfer cases
`timescale 1ns/1ps
`default_nettype none
`include "sldc_cfg.svh"
module tb;
  import sldc_pkg::*;
  typedef struct packed {logic [3:0] ty; logic [15:0] wd; logic [15:0] ex; logic [1:0] ext;} sldc_row_type;
  logic         core_clk, nrst, sel_wr, acc_wr, acc_rd, resync_req;
  logic [15:0]  sel_wdata, acc_wdata, sel_rdata, acc_rdata, d;
  logic [1:0]   sys_ctl_ext, ext_rdata, e;
  logic [15:0]  crc;
  sldc_req_type req;
  sldc_rsp_type rsp, r;
  int           bad_count, checks_done;
  // Writes and expected reads, line state drops bits 0, 1, 3
  sldc_row_type rows [15] = '{'{4'h0,16'h1234,16'h1234,2'h1}, '{4'h1,16'h8001,16'h8001,2'h2},
    '{4'h2,16'h2222,16'h2222,2'h3}, '{4'h3,16'h0333,16'h0333,2'h1}, '{4'h4,16'h4444,16'h4444,2'h2},
    '{4'h5,16'h0555,16'h0555,2'h3}, '{4'h6,16'h6666,16'h6666,2'h1}, '{4'h7,16'h7777,16'h7777,2'h2},
    '{4'h8,16'h8888,16'h8888,2'h3}, '{4'h9,16'h9999,16'h9999,2'h1}, '{4'ha,16'habcd,16'habcd,2'h2},
    '{4'hb,16'hffff,16'hfff4,2'h3}, '{4'hc,16'h0005,16'h0005,2'h1}, '{4'hd,16'h0006,16'h0006,2'h2},
    '{4'he,16'h0400,16'h0400,2'h3}};

  sldc_context dut_u (.core_clk(core_clk), .nrst(nrst), .sel_wr(sel_wr), .sel_wdata(sel_wdata),
    .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .sys_ctl_ext(sys_ctl_ext),
    .sel_rdata(sel_rdata), .acc_rdata(acc_rdata), .ext_rdata(ext_rdata), .resync_req(resync_req),
    .req(req), .rsp(rsp));
  sldc_engine_model eng_u (.core_clk(core_clk), .req(req), .rsp(rsp));

  // Clock
  always #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Selector then access write
  task automatic put(input logic [3:0] ln, ty, input logic [15:0] wd);
    sel_wr = 1'b1;
    sel_wdata = {4'h0, ty, 4'h0, ln};
    @(negedge core_clk);
    sel_wr = 1'b0;
    acc_wr = 1'b1;
    acc_wdata = wd;
    @(negedge core_clk);
    acc_wr = 1'b0;
  endtask : put
  task automatic get(input logic [3:0] ln, ty, output logic [15:0] rd, output logic [1:0] ex);
    sel_wr = 1'b1;
    sel_wdata = {4'h0, ty, 4'h0, ln};
    @(negedge core_clk);
    sel_wr = 1'b0;
    acc_rd = 1'b1;
    @(negedge core_clk);
    acc_rd = 1'b0;
    rd = acc_rdata;
    ex = ext_rdata;
  endtask : get
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ `SLDC_POLY_CRC16 : c >> 1;
    return c;
  endfunction : crc_byte
  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {core_clk, nrst, sel_wr, acc_wr, acc_rd, sel_wdata, acc_wdata, sys_ctl_ext} = '0;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    get(4'h0, 4'h0, d, e);
    chk({e, d}, 18'h0);
    foreach (rows[i]) begin
      sys_ctl_ext = rows[i].ext;
      put(4'h3, rows[i].ty, rows[i].wd);
      get(4'h3, rows[i].ty, d, e);
      chk(d, rows[i].ex);
      chk(e, rows[i].ty inside {4'h0, 4'h2, 4'h4, 4'h8, 4'h9} ? rows[i].ext : 2'h0);
    end
    sys_ctl_ext = 2'h2;
    // Unmarked primary run, three characters back to back
    put(4'h2, 4'h1, 16'hfffd);
    put(4'h2, 4'h0, 16'h0010);
    put(4'h2, 4'hc, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      eng_u.send(SLDC_OP_TX_CHAR, 4'h2, 8'h30, 8'h00, r);
      chk(r.mem_addr, 18'h20010 + i);
      chk({r.count_zero, r.mode}, {i == 2, 3'h2});
    end
    eng_u.idle();
    // Marked primary zero, then alternate table
    put(4'h5, 4'h1, 16'h7fff);
    put(4'h5, 4'h0, 16'h0100);
    put(4'h5, 4'h2, 16'h0300);
    put(4'h5, 4'h3, 16'hffff);
    put(4'h5, 4'h8, 16'h2000);
    put(4'h5, 4'h6, 16'h0000);
    put(4'h5, 4'he, 16'hc400);
    put(4'h5, 4'hb, 16'h0004);
    put(4'h5, 4'hc, 16'h0001);
    eng_u.send(SLDC_OP_TX_CHAR, 4'h5, 8'h41, 8'h08, r);
    chk(r.mem_addr, 18'h20100);
    chk(r.ctrl_addr, 18'h22041);
    chk({r.count_zero, r.mode}, 4'he);
    eng_u.send(SLDC_OP_TX_CHAR, 4'h5, 8'h42, 8'h00, r);
    chk({r.count_zero, r.mem_addr}, 19'h60300);
    eng_u.idle();
    get(4'h5, 4'hb, d, e);
    chk(d, 16'h0004);
    crc = crc_byte(16'h0000, 8'h41);
    eng_u.send(SLDC_OP_TX_CHECK, 4'h5, 8'h00, 8'h00, r);
    chk({r.check_valid, r.check_byte}, {1'b1, crc[7:0]});
    eng_u.send(SLDC_OP_TX_CHECK, 4'h5, 8'h00, 8'h00, r);
    chk({r.check_valid, r.check_byte}, {1'b1, crc[15:8]});
    eng_u.send(SLDC_OP_TX_CHECK, 4'h5, 8'h00, 8'h00, r);
    chk(r.check_valid, 1'b0);
    eng_u.idle();
    get(4'h5, 4'h6, d, e);
    chk(d, 16'h0000);
    // Marked receive zero stops storing
    put(4'h7, 4'h5, 16'h7fff);
    put(4'h7, 4'h4, 16'h0500);
    put(4'h7, 4'hb, 16'h6400);
    eng_u.send(SLDC_OP_RX_CHAR, 4'h7, 8'h55, 8'h08, r);
    chk({r.store_en, r.count_zero, r.rx_int, r.rx_int_code}, 11'h705);
    chk({r.mode, r.mem_addr}, 21'h0e0500);
    eng_u.send(SLDC_OP_RX_CHAR, 4'h7, 8'h56, 8'h00, r);
    chk(r.store_en, 1'b0);
    eng_u.idle();
    get(4'h7, 4'h4, d, e);
    chk(d, 16'h0501);
    get(4'h7, 4'he, d, e);
    chk(d, 16'h0020);
    get(4'h7, 4'h7, d, e);
    chk(d, crc_byte(16'h0000, 8'h55));
    put(4'h7, 4'h7, 16'h0000);
    get(4'h7, 4'h7, d, e);
    chk(d, 16'h0000);
    // Device status bits are sticky in line state
    eng_u.send(SLDC_OP_STATUS, 4'h7, 8'h08, 8'h00, r);
    chk({r.valid, r.line}, 5'h17);
    eng_u.idle();
    get(4'h7, 4'hb, d, e);
    chk(d, 16'h6408);
    tally_and_finish();
  end
endmodule : tb
bind sldc_context sldc_context_assertions chk_u (.core_clk(core_clk), .nrst(nrst), .sel_wr(sel_wr),
  .sel_wdata(sel_wdata), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .sel_rdata(sel_rdata),
  .acc_rdata(acc_rdata), .resync_req(resync_req), .req(req), .rsp(rsp));
`default_nettype wire
